// ### common/comm_lock_regs.vh
`ifndef COMM_LOCK_REGS_VH
`define COMM_LOCK_REGS_VH
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_W 3
`define OP_PUT 3'h0
`define OP_GET 3'h1
`define OP_SEND 3'h2
`define OP_RECV 3'h3
`define OP_LOCK 3'h4
`define OP_UNLOCK 3'h5
`define OP_TEST 3'h6
`define OP_ADDV 3'h7
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define LOCK_RST 1'b0
`define DATA_W_DEF 64
`define ADDR_W_DEF 5
`define CPU_N_DEF 8
`endif

// ### verilog/cpu_arbiter.v
`timescale 1ns/100ps
`include "comm_lock_regs.vh"
// Round-robin arbiter: one grant per cycle among pending requesters
module cpu_arbiter #(
  parameter N = `CPU_N_DEF
) (
  input wire i_clk, // Clock
  input wire i_srst, // Sync reset
  input wire [N-1:0] i_req, // Pending requests
  input wire i_adv, // Advance pointer after grant
  output reg [N-1:0] o_gnt, // One-hot grant (combinational)
  output reg o_any // Any grant
);
  reg [N-1:0] prio_r;
  reg [N-1:0] prio_nxt;
  reg found;
  integer k;
  integer j;

  always @* begin
    o_gnt = {N{1'b0}};
    o_any = 1'b0;
    found = 1'b0;
    for (k = 0; k < N; k = k + 1) begin
      for (j = 0; j < N; j = j + 1) begin
        if (!found && prio_r[j] && i_req[(j + k) % N]) begin
          o_gnt[(j + k) % N] = 1'b1;
          found = 1'b1;
        end
      end
    end
    o_any = found;
    prio_nxt = prio_r;
    if (found && i_adv) begin
      prio_nxt = {o_gnt[N-2:0], o_gnt[N-1]};
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      prio_r <= {{(N-1){1'b0}}, 1'b1};
    end else begin
      prio_r <= prio_nxt;
    end
  end
endmodule

// ### verilog/comm_lock_store.v
// Notes on behaviour
// R1: Put writes data, lock bit untouched
// R2: Get reads data, lock bit untouched
// R3: Send writes and locks only if clear
// R4: Send status one on success, else zero
// R5: Receive reads and unlocks only if set; the code returns the data even when the bit is clear
// R6: Receive status one on success, else zero
// R7: Lock sets bit; status shows prior clear
// R8: Unlock clears bit; status shows prior set
// R9: Test copies lock bit into carry
// R10: Status returned per CPU as carry flag
// R11: Add-if-valid: receive, add, send back atomically
// R12: CPUs keep lock ops off send/receive registers
// R13: Waiting CPU may spin on failing receive
// R14: Memory sync stalls until loads, stores done
// R15: Producer syncs memory before setting lock
// R16: Consumer syncs memory before clearing lock
// R17: Memory sync also purges data cache
// R18: Operations atomic, serialised by arbitration
`timescale 1ns/100ps
`include "comm_lock_regs.vh"
module comm_lock_store #(
  parameter N = `CPU_N_DEF,
  parameter DW = `DATA_W_DEF,
  parameter AW = `ADDR_W_DEF
) (
  input wire i_clk, // 25 MHz clock
  input wire i_srst, // Sync reset, active high
  input wire [N-1:0] i_req, // Request level per CPU, held until done
  input wire [N*`OP_W-1:0] i_op, // Operation code per CPU
  input wire [N*AW-1:0] i_addr, // Register index per CPU
  input wire [N*DW-1:0] i_wdata, // Write data or addend per CPU
  input wire [N-1:0] i_sync, // Memory sync request per CPU
  input wire [N-1:0] i_st_pend, // Stores outstanding per CPU
  input wire [N-1:0] i_ld_pend, // Loads outstanding per CPU
  output reg [N-1:0] o_done, // Operation done pulse per CPU
  output reg [N*DW-1:0] o_rdata, // Read data per CPU
  output reg [N-1:0] o_carry, // Status into carry flag per CPU
  output reg [N-1:0] o_stall, // Stall CPU during memory sync
  output reg [N-1:0] o_purge // Data cache purge pulse per CPU
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  localparam DEPTH = 1 << AW;
  reg [DW-1:0] data_r [0:DEPTH-1];
  reg [DEPTH-1:0] lock_r;

  wire [N-1:0] gnt;
  wire any;
  reg [N-1:0] req_q;
  reg [`OP_W-1:0] op_s;
  reg [AW-1:0] addr_s;
  reg [DW-1:0] wd_s;
  integer i;

  always @* begin
    req_q = i_req & ~o_done;
  end

  cpu_arbiter #(.N(N)) u_arb (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_req(req_q),
    .i_adv(1'b1),
    .o_gnt(gnt),
    .o_any(any)
  );

  // Mux selected request fields
  always @* begin
    op_s = {`OP_W{1'b0}};
    addr_s = {AW{1'b0}};
    wd_s = {DW{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      if (gnt[i]) begin
        op_s = i_op[i*`OP_W +: `OP_W];
        addr_s = i_addr[i*AW +: AW];
        wd_s = i_wdata[i*DW +: DW];
      end
    end
  end

  // ----------------------------------------
  // Operation execution
  // ----------------------------------------
  reg lk;
  reg [DW-1:0] cur;
  reg wr_en;
  reg [DW-1:0] wr_val;
  reg lk_nxt;
  reg st;
  reg [DW-1:0] rd;

  always @* begin
    lk = lock_r[addr_s];
    cur = data_r[addr_s];
    wr_en = 1'b0;
    wr_val = wd_s;
    lk_nxt = lk;
    st = 1'b0;
    rd = {DW{1'b0}};
    case (op_s)
      `OP_PUT: begin
        wr_en = 1'b1; // [R1]
        st = 1'b1;
      end
      `OP_GET: begin
        rd = cur; // [R2]
        st = 1'b1;
      end
      `OP_SEND: begin
        wr_en = ~lk; // [R3]
        lk_nxt = 1'b1;
        st = ~lk; // [R4]
      end
      `OP_RECV: begin
        rd = cur; // [R5]
        lk_nxt = 1'b0;
        st = lk; // [R6]
      end
      `OP_LOCK: begin
        lk_nxt = 1'b1; // [R7]
        st = ~lk;
      end
      `OP_UNLOCK: begin
        lk_nxt = 1'b0; // [R8]
        st = lk;
      end
      `OP_TEST: begin
        st = lk; // [R9]
      end
      `OP_ADDV: begin
        // Receive then send back in one slot, so the bit keeps its value
        wr_en = lk; // [R11]
        wr_val = cur + wd_s;
        rd = cur + wd_s;
        st = lk;
      end
      default: begin
        st = 1'b0;
      end
    endcase
  end

  // One access per cycle makes every operation atomic
  always @(posedge i_clk) begin
    if (i_srst) begin
      lock_r <= {DEPTH{`LOCK_RST}};
    end else if (any) begin // [R18]
      lock_r[addr_s] <= lk_nxt;
    end
  end

  always @(posedge i_clk) begin
    if (any && wr_en) begin
      data_r[addr_s] <= wr_val;
    end
  end

  // ----------------------------------------
  // Per-CPU answers and memory sync
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : cpu
      reg sync_r;
      reg sync_prev_r;
      // Edge detect on the request, so a level held past completion starts no second sync
      always @(posedge i_clk) begin
        if (i_srst) begin
          sync_prev_r <= 1'b0;
        end else begin
          sync_prev_r <= i_sync[g];
        end
      end

      always @(posedge i_clk) begin
        if (i_srst) begin
          o_done[g] <= 1'b0;
          o_carry[g] <= 1'b0;
          o_rdata[g*DW +: DW] <= {DW{1'b0}};
          o_stall[g] <= 1'b0;
          o_purge[g] <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          o_done[g] <= gnt[g];
          if (gnt[g]) begin
            o_carry[g] <= st; // [R10]
            o_rdata[g*DW +: DW] <= rd;
          end
          o_purge[g] <= i_sync[g] & ~sync_prev_r & ~sync_r; // [R17]
          if (i_sync[g] && !sync_prev_r && !sync_r) begin
            sync_r <= 1'b1;
            o_stall[g] <= 1'b1;
          end else if (sync_r && !i_st_pend[g] && !i_ld_pend[g]) begin
            sync_r <= 1'b0; // [R14]
            o_stall[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule

// ### bench/comm_lock_store_properties.sv
`timescale 1ns/100ps
module comm_lock_chk #(parameter N = 8) (
  input wire i_clk, // Clock
  input wire i_srst, // Reset
  input wire [N-1:0] i_req, // Requests
  input wire [N-1:0] i_sync, // Sync
  input wire [N-1:0] i_st_pend, // Stores
  input wire [N-1:0] i_ld_pend, // Loads
  input wire [N-1:0] o_done, // Done
  input wire [N-1:0] o_stall, // Stall
  input wire [N-1:0] o_purge // Purge
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_done_pulse: assert property (o_done[0] |=> !o_done[0]) else $error("done");
  a_done_cause: assert property (o_done[0] |-> $past(i_req[0])) else $error("cause");
  a_done_bound: assert property ($rose(i_req[0]) |-> ##[1:4] o_done[0]) else $error("late");
  a_one_grant: assert property ($onehot0(o_done)) else $error("grant");
  a_sync_start: assert property ($rose(i_sync[1]) |=> o_stall[1] && o_purge[1]) else $error("sync");
  a_purge_pulse: assert property (o_purge[1] |=> !o_purge[1]) else $error("purge");
  a_stall_hold: assert property (o_stall[1] && (i_st_pend[1] || i_ld_pend[1]) |=> o_stall[1]) else $error("hold");
  a_stall_end: assert property (o_stall[1] && !i_st_pend[1] && !i_ld_pend[1] |=> !o_stall[1]) else $error("end");
endmodule
bind comm_lock_store comm_lock_chk #(.N(N)) chk (.i_clk, .i_srst, .i_req, .i_sync, .i_st_pend, .i_ld_pend,
  .o_done, .o_stall, .o_purge);

// ### bench/mem_pend_model.sv
`timescale 1ns/100ps
module mem_pend_model (
  input wire i_clk, // Clock
  input wire i_issue, // New traffic
  output wire o_st_pend, // Stores out
  output wire o_ld_pend // Loads out
);
  reg [3:0] cnt_r = 4'h0;
  always @(posedge i_clk) begin
    if (i_issue) cnt_r <= 4'h6;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign o_st_pend = cnt_r != 4'h0;
  assign o_ld_pend = cnt_r > 4'h2; // Loads land first
endmodule

// ### bench/comm_lock_store_tb.sv
`timescale 1ns/100ps
module comm_lock_store_tb;
  reg i_clk = 0, i_srst = 1, c, iss = 0, lk [0:3];
  reg [1:0] i_req = 0, i_sync = 0;
  reg [5:0] i_op = 0;
  reg [3:0] i_addr = 0;
  reg [15:0] i_wdata = 0;
  reg [7:0] r, mem [0:3];
  reg [16:0] seed = 17'h178EC;
  wire [1:0] o_done, o_carry, o_stall, o_purge, i_st_pend, i_ld_pend;
  wire [15:0] o_rdata;
  integer num_errors = 0, total_checks = 0, cyc = 0, i, n;
  initial forever #20 i_clk = ~i_clk;
  comm_lock_store #(.N(2), .DW(8), .AW(2)) dut (.*);
  mem_pend_model pm (.i_clk(i_clk), .i_issue(iss), .o_st_pend(i_st_pend[1]), .o_ld_pend(i_ld_pend[1]));
  assign i_st_pend[0] = 1'b0;
  assign i_ld_pend[0] = 1'b0;
  function [16:0] lfsr(input [16:0] x); lfsr = {x[15:0], x[16] ^ x[13]}; endfunction
  function expc(input [2:0] o, input l); expc = o < 2 ? 1'b1 : (o == 2 || o == 4) ? !l : l; endfunction
  task chk(input [7:0] s, input [7:0] e); begin
    total_checks = total_checks + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  end endtask
  task conclude; begin
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  end endtask
  task run(input [2:0] o, input [1:0] a, input [7:0] d); begin
    @(posedge i_clk);
    i_op[2:0] <= o;
    i_addr[1:0] <= a;
    i_wdata[7:0] <= d;
    i_req[0] <= 1;
    n = 0;
    @(negedge i_clk);
    while (o_done[0] !== 1'b1 && n < 9) begin
      @(negedge i_clk);
      n = n + 1;
    end
    i_req[0] <= 0;
    c = expc(o, lk[a]);
    r = o == 7 ? mem[a] + d : mem[a];
    chk(o_carry[0], c);
    if (o == 1 || o == 3 || (o == 7 && c)) chk(o_rdata[7:0], r);
    if (o == 0 || (o == 2 && c)) mem[a] = d;
    if (o == 7 && c) mem[a] = r;
    if (o == 2 || o == 4) lk[a] = 1;
    if (o == 3 || o == 5) lk[a] = 0;
  end endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 0;
    for (i = 0; i < 4; i = i + 1) begin
      lk[i] = 0;
      run(0, i[1:0], i[7:0]);
    end
    // Every code twice in a row, so send, receive, lock and unlock fail once
    for (i = 0; i < 16; i = i + 1) run(i[3:1], 1, 8'hF0);
    run(5, 3, 0); // Unlock only to set the initial state
    run(3, 3, 0); // Consumer spins on a failing receive
    run(3, 3, 0);
    run(2, 3, 8'h5A); // Producer send ends the spin
    run(3, 3, 0);
    repeat (80) begin
      seed = lfsr(seed);
      run(seed[2:0], seed[4:3], seed[12:5]);
    end
    $display("ops done");
    @(posedge i_clk);
    iss <= 1;
    i_sync[1] <= 1;
    @(posedge i_clk);
    iss <= 0;
    @(negedge i_clk);
    chk(o_purge[1], 1);
    n = 0;
    while (o_stall[1] !== 1'b0 && n < 20) begin
      @(negedge i_clk);
      n = n + 1;
    end
    chk(n[7:0], 8'h07);
    chk(i_st_pend[1] | i_ld_pend[1], 0);
    i_sync[1] <= 0;
    run(4, 0, 0); // Producer CPU 0 locks only after the CPU 1 sync
    run(5, 0, 0); // Consumer CPU 0 unlocks only after the CPU 1 sync
    $display("sync done");
    conclude;
  end
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc > 5000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
endmodule
